// ### src/apc_pkg.sv
// Package for the analog path control register bank: offsets, fields, defaults, carrier struct
package apc_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 9;
  localparam int GAIN_W = 6;
  localparam int BST_W = 3;

  localparam logic [6:0] OFS_INPUT_SIGNAL = 7'h2C;
  localparam logic [6:0] OFS_PGA_GAIN = 7'h2D;
  localparam logic [6:0] OFS_BOOST_CTRL = 7'h2F;
  localparam logic [6:0] OFS_OUTPUT_OPT = 7'h31;
  localparam logic [6:0] OFS_SPK_MIXER = 7'h32;

  localparam logic [8:0] RST_INPUT_SIGNAL = 9'h003;
  localparam logic [8:0] RST_PGA_GAIN = 9'h010;
  localparam logic [8:0] RST_BOOST_CTRL = 9'h100;
  localparam logic [8:0] RST_OUTPUT_OPT = 9'h002;
  localparam logic [8:0] RST_SPK_MIXER = 9'h001;

  // Writable bits; all others are reserved zero
  localparam logic [8:0] MSK_INPUT_SIGNAL = 9'h18F;
  localparam logic [8:0] MSK_PGA_GAIN = 9'h0FF;
  localparam logic [8:0] MSK_BOOST_CTRL = 9'h177;
  localparam logic [8:0] MSK_OUTPUT_OPT = 9'h00F;
  localparam logic [8:0] MSK_SPK_MIXER = 9'h023;

  // Input signal control fields
  localparam int POS_BIAS_LEVEL = 7;
  localparam int POS_AUX_AMP_MODE = 3;
  localparam int POS_AUX_TO_PGA = 2;
  localparam int POS_NEG_MIC_TO_PGA = 1;
  localparam int POS_POS_MIC_TO_PGA = 0;
  // PGA gain fields
  localparam int POS_PGA_ZC_EN = 7;
  localparam int POS_PGA_MUTE = 6;
  localparam int POS_PGA_GAIN = 0;
  // Boost control fields
  localparam int POS_PGA_BOOST = 8;
  localparam int POS_POS_MIC_BOOST = 4;
  localparam int POS_AUX_BOOST = 0;
  // Output options fields
  localparam int POS_MONO_BOOST = 3;
  localparam int POS_SPK_BOOST = 2;
  localparam int POS_THERMAL_EN = 1;
  localparam int POS_OUT_RES = 0;
  // Speaker mixer fields
  localparam int POS_AUX_TO_SPK = 5;
  localparam int POS_BYP_TO_SPK = 1;
  localparam int POS_DAC_TO_SPK = 0;

  // PGA gain in quarter dB: code 0 at -12.00 dB, 0.75 dB per step
  localparam logic [8:0] PGA_QDB_STEP = 9'h003;
  localparam logic [8:0] PGA_QDB_OFFSET = 9'h030;
  // Boost in dB: 3 dB per step, code 1 at -12 dB
  localparam logic [5:0] BST_DB_STEP = 6'h03;
  localparam logic [5:0] BST_DB_OFFSET = 6'h0F;
  // Output boost in tenths of the reference
  localparam logic [3:0] OUT_BOOST_X10_LO = 4'hA;
  localparam logic [3:0] OUT_BOOST_X10_HI = 4'hF;
  // Microphone bias in percent of the analog supply
  localparam logic [6:0] BIAS_PCT_00_M0 = 7'h5A;
  localparam logic [6:0] BIAS_PCT_00_M1 = 7'h55;
  localparam logic [6:0] BIAS_PCT_01_M0 = 7'h41;
  localparam logic [6:0] BIAS_PCT_01_M1 = 7'h3C;
  localparam logic [6:0] BIAS_PCT_10_M0 = 7'h4B;
  localparam logic [6:0] BIAS_PCT_10_M1 = 7'h46;
  localparam logic [6:0] BIAS_PCT_11 = 7'h32;

  typedef struct packed {
    logic aux_amp_mode;
    logic aux_to_pga_sel;
    logic neg_mic_to_pga_sel;
    logic pos_mic_to_pga_sel;
    logic [6:0] mic_bias_pct;
    logic pga_mute;
    logic signed [8:0] pga_gain_qdb;
    logic pga_boost_20db;
    logic pos_mic_boost_conn;
    logic signed [4:0] pos_mic_boost_db;
    logic aux_boost_conn;
    logic signed [4:0] aux_boost_db;
    logic [3:0] mono_out_boost_x10;
    logic [3:0] speaker_out_boost_x10;
    logic thermal_shutdown_en;
    logic analog_out_resistance;
    logic aux_to_speaker_mix;
    logic bypass_to_speaker_mix;
    logic dac_to_speaker_mix;
  } apc_ctrl_s;
endpackage

// ### src/apc_zc_gain.sv
// PGA gain update stage with optional zero-cross deferral
`timescale 1ns/1ps
module apc_zc_gain #(
  parameter int GAIN_W = 6,
  parameter logic [5:0] RST_CODE = 6'h10
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic zc_en_i,
  input wire logic gain_wr_i,
  input wire logic [GAIN_W-1:0] gain_code_i,
  input wire logic signal_sign_i,
  output logic [GAIN_W-1:0] applied_code_o
);
  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  logic level_q;
  logic level_d;
  logic pend_q;
  logic pend_d;
  logic [GAIN_W-1:0] applied_q;
  logic [GAIN_W-1:0] applied_d;
  wire logic zc_evt;

  // A crossing counts only once the last two stages agree on a new sign
  assign zc_evt = (sync2_q == sync3_q) && (sync3_q != level_q);
  assign level_d = zc_evt ? sync3_q : level_q;
  // A write in the crossing cycle re-arms, so set wins over clear
  assign pend_d = (gain_wr_i && zc_en_i) ? 1'b1 : (zc_evt ? 1'b0 : pend_q);
  assign applied_d = !zc_en_i ? gain_code_i :
                     (pend_q && zc_evt && !gain_wr_i) ? gain_code_i : applied_q;
  assign applied_code_o = applied_q;

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      level_q <= 1'b0;
      pend_q <= 1'b0;
      applied_q <= RST_CODE;
    end
    else
    begin
      sync1_q <= signal_sign_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      level_q <= level_d;
      pend_q <= pend_d;
      applied_q <= applied_d;
    end
  end
endmodule

// ### src/apc_regs.sv
// Analog path control register bank with decoded control outputs
`timescale 1ns/1ps
module apc_regs #(
  parameter int ADDR_W = apc_pkg::ADDR_W,
  parameter int DATA_W = apc_pkg::DATA_W
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic reg_wr_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  input wire logic mic_bias_mode_sel_i,
  input wire logic pga_signal_sign_i,
  output apc_pkg::apc_ctrl_s ctrl_o
);
  logic [8:0] isc_q;
  logic [8:0] gain_q;
  logic [8:0] boost_q;
  logic [8:0] outopt_q;
  logic [8:0] mix_q;
  logic [8:0] rdata_q;
  apc_pkg::apc_ctrl_s ctrl_q;
  apc_pkg::apc_ctrl_s ctrl_d;
  wire logic [8:0] isc_d;
  wire logic [8:0] gain_d;
  wire logic [8:0] boost_d;
  wire logic [8:0] outopt_d;
  wire logic [8:0] mix_d;
  wire logic [8:0] rdata_d;
  wire logic hit_isc;
  wire logic hit_gain;
  wire logic hit_boost;
  wire logic hit_outopt;
  wire logic hit_mix;
  wire logic [5:0] applied_code;
  wire logic [1:0] bias_level;
  wire logic [2:0] pos_bst_code;
  wire logic [2:0] aux_bst_code;

  function automatic logic [8:0] wr_merge(input logic hit, input logic [8:0] cur,
                                          input logic [8:0] wdata, input logic [8:0] mask);
    // Reserved bits are forced to zero on every write
    wr_merge = hit ? (wdata & mask) : cur;
  endfunction

  function automatic logic signed [4:0] boost_db(input logic [2:0] code);
    logic [5:0] raw;
    raw = 6'h00;
    raw = 6'({3'b000, code} * apc_pkg::BST_DB_STEP) - apc_pkg::BST_DB_OFFSET;
    // Code 0 is a disconnected path, so its dB value is don't-care and held at zero
    boost_db = (code == 3'h0) ? 5'sh00 : $signed(raw[4:0]);
  endfunction

  function automatic logic [3:0] out_boost(input logic sel);
    out_boost = sel ? apc_pkg::OUT_BOOST_X10_HI : apc_pkg::OUT_BOOST_X10_LO;
  endfunction

  function automatic logic [6:0] bias_pct(input logic [1:0] level, input logic mode);
    logic [6:0] pct;
    pct = apc_pkg::BIAS_PCT_11;
    case (level)
      2'h0: pct = mode ? apc_pkg::BIAS_PCT_00_M1 : apc_pkg::BIAS_PCT_00_M0;
      2'h1: pct = mode ? apc_pkg::BIAS_PCT_01_M1 : apc_pkg::BIAS_PCT_01_M0;
      2'h2: pct = mode ? apc_pkg::BIAS_PCT_10_M1 : apc_pkg::BIAS_PCT_10_M0;
      default: pct = apc_pkg::BIAS_PCT_11;
    endcase
    bias_pct = pct;
  endfunction

  assign hit_isc = reg_wr_i && (reg_addr_i == apc_pkg::OFS_INPUT_SIGNAL);
  assign hit_gain = reg_wr_i && (reg_addr_i == apc_pkg::OFS_PGA_GAIN);
  assign hit_boost = reg_wr_i && (reg_addr_i == apc_pkg::OFS_BOOST_CTRL);
  assign hit_outopt = reg_wr_i && (reg_addr_i == apc_pkg::OFS_OUTPUT_OPT);
  assign hit_mix = reg_wr_i && (reg_addr_i == apc_pkg::OFS_SPK_MIXER);

  assign isc_d = wr_merge(hit_isc, isc_q, reg_wdata_i, apc_pkg::MSK_INPUT_SIGNAL);
  assign gain_d = wr_merge(hit_gain, gain_q, reg_wdata_i, apc_pkg::MSK_PGA_GAIN);
  assign boost_d = wr_merge(hit_boost, boost_q, reg_wdata_i, apc_pkg::MSK_BOOST_CTRL);
  assign outopt_d = wr_merge(hit_outopt, outopt_q, reg_wdata_i, apc_pkg::MSK_OUTPUT_OPT);
  assign mix_d = wr_merge(hit_mix, mix_q, reg_wdata_i, apc_pkg::MSK_SPK_MIXER);

  // Unmapped addresses read as zero
  assign rdata_d = (reg_addr_i == apc_pkg::OFS_INPUT_SIGNAL) ? isc_q :
                   (reg_addr_i == apc_pkg::OFS_PGA_GAIN) ? gain_q :
                   (reg_addr_i == apc_pkg::OFS_BOOST_CTRL) ? boost_q :
                   (reg_addr_i == apc_pkg::OFS_OUTPUT_OPT) ? outopt_q :
                   (reg_addr_i == apc_pkg::OFS_SPK_MIXER) ? mix_q : 9'h000;

  // The gain write pulse is taken from the strobe so the deferral arms on the write itself;
  // the enable comes from the next register value so a write that turns deferral on arms it
  apc_zc_gain #(
    .GAIN_W(apc_pkg::GAIN_W),
    .RST_CODE(apc_pkg::RST_PGA_GAIN[5:0])
  ) u_zc_gain (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .zc_en_i(gain_d[apc_pkg::POS_PGA_ZC_EN]),
    .gain_wr_i(hit_gain),
    .gain_code_i(gain_q[apc_pkg::POS_PGA_GAIN +: apc_pkg::GAIN_W]),
    .signal_sign_i(pga_signal_sign_i),
    .applied_code_o(applied_code)
  );

  assign bias_level = isc_q[apc_pkg::POS_BIAS_LEVEL +: 2];
  assign pos_bst_code = boost_q[apc_pkg::POS_POS_MIC_BOOST +: apc_pkg::BST_W];
  assign aux_bst_code = boost_q[apc_pkg::POS_AUX_BOOST +: apc_pkg::BST_W];

  always_comb
  begin
    ctrl_d = '0;
    ctrl_d.aux_amp_mode = isc_q[apc_pkg::POS_AUX_AMP_MODE];
    ctrl_d.aux_to_pga_sel = isc_q[apc_pkg::POS_AUX_TO_PGA];
    ctrl_d.neg_mic_to_pga_sel = isc_q[apc_pkg::POS_NEG_MIC_TO_PGA];
    // Not interlocked with the boost path; software keeps this clear when that path is used
    ctrl_d.pos_mic_to_pga_sel = isc_q[apc_pkg::POS_POS_MIC_TO_PGA];
    ctrl_d.mic_bias_pct = bias_pct(bias_level, mic_bias_mode_sel_i);
    ctrl_d.pga_mute = gain_q[apc_pkg::POS_PGA_MUTE];
    ctrl_d.pga_gain_qdb = $signed(9'({3'b000, applied_code} * apc_pkg::PGA_QDB_STEP)
                          - apc_pkg::PGA_QDB_OFFSET);
    ctrl_d.pga_boost_20db = boost_q[apc_pkg::POS_PGA_BOOST];
    ctrl_d.pos_mic_boost_conn = (pos_bst_code != 3'h0);
    ctrl_d.pos_mic_boost_db = boost_db(pos_bst_code);
    ctrl_d.aux_boost_conn = (aux_bst_code != 3'h0);
    ctrl_d.aux_boost_db = boost_db(aux_bst_code);
    ctrl_d.mono_out_boost_x10 = out_boost(outopt_q[apc_pkg::POS_MONO_BOOST]);
    ctrl_d.speaker_out_boost_x10 = out_boost(outopt_q[apc_pkg::POS_SPK_BOOST]);
    ctrl_d.thermal_shutdown_en = outopt_q[apc_pkg::POS_THERMAL_EN];
    ctrl_d.analog_out_resistance = outopt_q[apc_pkg::POS_OUT_RES];
    ctrl_d.aux_to_speaker_mix = mix_q[apc_pkg::POS_AUX_TO_SPK];
    ctrl_d.bypass_to_speaker_mix = mix_q[apc_pkg::POS_BYP_TO_SPK];
    ctrl_d.dac_to_speaker_mix = mix_q[apc_pkg::POS_DAC_TO_SPK];
  end

  assign reg_rdata_o = rdata_q;
  assign ctrl_o = ctrl_q;

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      isc_q <= apc_pkg::RST_INPUT_SIGNAL;
      gain_q <= apc_pkg::RST_PGA_GAIN;
      boost_q <= apc_pkg::RST_BOOST_CTRL;
      outopt_q <= apc_pkg::RST_OUTPUT_OPT;
      mix_q <= apc_pkg::RST_SPK_MIXER;
      rdata_q <= 9'h000;
      ctrl_q <= '0;
    end
    else
    begin
      isc_q <= isc_d;
      gain_q <= gain_d;
      boost_q <= boost_d;
      outopt_q <= outopt_d;
      mix_q <= mix_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
    end
  end
endmodule

// ### bench/apc_regs_properties.sv
// Concurrent checks on the analog path control register bank ports
`timescale 1ns/1ps
module apc_regs_properties (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic reg_wr_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [8:0] reg_wdata_i,
  input wire logic [8:0] reg_rdata_o,
  input wire logic mic_bias_mode_sel_i,
  input wire logic pga_signal_sign_i,
  input apc_pkg::apc_ctrl_s ctrl_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // Controls show two samples after the write: register stage, then decode stage
  wire w2c = reg_wr_i && reg_addr_i == apc_pkg::OFS_INPUT_SIGNAL;
  wire w2d = reg_wr_i && reg_addr_i == apc_pkg::OFS_PGA_GAIN;
  wire w2f = reg_wr_i && reg_addr_i == apc_pkg::OFS_BOOST_CTRL;
  wire w31 = reg_wr_i && reg_addr_i == apc_pkg::OFS_OUTPUT_OPT;
  wire w32 = reg_wr_i && reg_addr_i == apc_pkg::OFS_SPK_MIXER;
  AST_AUX_ROUTING: assert property (w2c |-> ##2
    {ctrl_o.aux_amp_mode, ctrl_o.aux_to_pga_sel, ctrl_o.neg_mic_to_pga_sel}
    == $past(reg_wdata_i[3:1], 2)) else $error("input routing bits not decoded");
  AST_BIAS_HALF: assert property (w2c && reg_wdata_i[8:7] == 2'h3 |-> ##2
    ctrl_o.mic_bias_pct == 7'h32) else $error("bias level three not half supply");
  // One cycle more when the gain goes through the zero-cross stage with deferral off
  AST_GAIN_DIRECT: assert property (w2d && !reg_wdata_i[7] ##1 !w2d |-> ##2
    ctrl_o.pga_gain_qdb == 9'(3 * $past(reg_wdata_i[5:0], 3) - 48))
    else $error("pga gain not applied directly");
  AST_PGA_MUTE: assert property (w2d |-> ##2
    ctrl_o.pga_mute == $past(reg_wdata_i[6], 2)) else $error("pga mute mismatch");
  AST_POS_BOOST: assert property (w2f |-> ##2
    ctrl_o.pos_mic_boost_conn == ($past(reg_wdata_i[6:4], 2) != 3'h0))
    else $error("positive mic boost connection mismatch");
  AST_AUX_BOOST: assert property (w2f && reg_wdata_i[2:0] != 3'h0 |-> ##2
    ctrl_o.aux_boost_db == 5'(3 * $past(reg_wdata_i[2:0], 2) - 15))
    else $error("aux boost gain mismatch");
  AST_PGA_BOOST: assert property (w2f |-> ##2
    ctrl_o.pga_boost_20db == $past(reg_wdata_i[8], 2)) else $error("pga boost mismatch");
  AST_OUT_BOOST: assert property (w31 |-> ##2
    ctrl_o.speaker_out_boost_x10 == ($past(reg_wdata_i[2], 2) ? 4'hF : 4'hA))
    else $error("speaker boost mismatch");
  AST_SPK_MIX: assert property (w32 |-> ##2
    {ctrl_o.aux_to_speaker_mix, ctrl_o.bypass_to_speaker_mix, ctrl_o.dac_to_speaker_mix}
    == {$past(reg_wdata_i[5], 2), $past(reg_wdata_i[1:0], 2)}) else $error("mixer mismatch");
  AST_RESERVED_ZERO: assert property (reg_addr_i == apc_pkg::OFS_OUTPUT_OPT |=>
    reg_rdata_o[8:4] == 5'h00) else $error("reserved bits read nonzero");
endmodule
bind apc_regs apc_regs_properties i_props (.mclk_i(mclk_i), .reset_i(reset_i),
  .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .mic_bias_mode_sel_i(mic_bias_mode_sel_i),
  .pga_signal_sign_i(pga_signal_sign_i), .ctrl_o(ctrl_o));

// ### bench/test_apc_regs.sv
// Self-checking bench for the analog path control register bank
`timescale 1ns/1ps
module test_apc_regs;
  logic mclk_i = 0, reset_i = 1, reg_wr_i = 0, mic_bias_mode_sel_i = 0, pga_signal_sign_i = 0;
  logic [6:0] reg_addr_i = 7'h00;
  logic [8:0] reg_wdata_i = 9'h000;
  logic [8:0] reg_rdata_o;
  apc_pkg::apc_ctrl_s ctrl_o;
  // Model of offsets 0x2C to 0x33; unmapped slots keep a zero mask
  logic [8:0] mem [0:7] = '{9'h003, 9'h010, 9'h000, 9'h100, 9'h000, 9'h002, 9'h001, 9'h000};
  logic [8:0] msk [0:7] = '{apc_pkg::MSK_INPUT_SIGNAL, apc_pkg::MSK_PGA_GAIN, 9'h000,
    apc_pkg::MSK_BOOST_CTRL, 9'h000, apc_pkg::MSK_OUTPUT_OPT, apc_pkg::MSK_SPK_MIXER, 9'h000};
  int num_errors = 0, n_checks = 0, seed = 32'he2f0, gcode = 16, i, k;
  logic [6:0] ra;
  logic [8:0] rv;
  int bias [0:7] = '{90, 85, 65, 60, 75, 70, 50, 50};
  apc_regs i_dut (.mclk_i(mclk_i), .reset_i(reset_i), .reg_wr_i(reg_wr_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .mic_bias_mode_sel_i(mic_bias_mode_sel_i), .pga_signal_sign_i(pga_signal_sign_i),
    .ctrl_o(ctrl_o));
  initial
  begin
    forever #25 mclk_i = ~mclk_i;
  end
  task automatic conclude();
    if (num_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic rd(logic [6:0] a);
    reg_addr_i = a;
    @(negedge mclk_i);
    n_checks++;
    if (reg_rdata_o !== mem[3'(a - 7'h2C)])
    begin
      num_errors++;
      $display("unexpected rdata %h: expected %h seen %h", a, mem[3'(a - 7'h2C)], reg_rdata_o);
    end
  endtask
  task automatic chk_ctl();
    apc_pkg::apc_ctrl_s e;
    e.aux_amp_mode = mem[0][3];
    e.aux_to_pga_sel = mem[0][2];
    e.neg_mic_to_pga_sel = mem[0][1];
    e.pos_mic_to_pga_sel = mem[0][0];
    e.mic_bias_pct = 7'(bias[{mem[0][8:7], mic_bias_mode_sel_i}]);
    e.pga_mute = mem[1][6];
    e.pga_gain_qdb = 9'(3 * gcode - 48);
    e.pga_boost_20db = mem[3][8];
    e.pos_mic_boost_conn = mem[3][6:4] != 3'h0;
    e.pos_mic_boost_db = e.pos_mic_boost_conn ? 5'(3 * mem[3][6:4] - 15) : 5'h00;
    e.aux_boost_conn = mem[3][2:0] != 3'h0;
    e.aux_boost_db = e.aux_boost_conn ? 5'(3 * mem[3][2:0] - 15) : 5'h00;
    e.mono_out_boost_x10 = mem[5][3] ? 4'hF : 4'hA;
    e.speaker_out_boost_x10 = mem[5][2] ? 4'hF : 4'hA;
    e.thermal_shutdown_en = mem[5][1];
    e.analog_out_resistance = mem[5][0];
    e.aux_to_speaker_mix = mem[6][5];
    e.bypass_to_speaker_mix = mem[6][1];
    e.dac_to_speaker_mix = mem[6][0];
    n_checks++;
    if (ctrl_o !== e)
    begin
      num_errors++;
      $display("unexpected ctrl_o: expected %h seen %h", e, ctrl_o);
    end
  endtask
  // Leaves the strobe high so back-to-back writes never re-assign it in one step
  task automatic wr(logic [6:0] a, logic [8:0] d);
    reg_wr_i = 1;
    reg_addr_i = a;
    reg_wdata_i = d;
    mem[3'(a - 7'h2C)] = d & msk[3'(a - 7'h2C)];
    if (a == apc_pkg::OFS_PGA_GAIN && !d[7])
      gcode = d[5:0];
    @(negedge mclk_i);
  endtask
  task automatic settle(int n);
    reg_wr_i = 0;
    repeat (n) @(negedge mclk_i);
  endtask
  initial
  begin
    #200us;
    num_errors++;
    conclude();
  end
  initial
  begin
    repeat (4) @(negedge mclk_i);
    reset_i = 0;
    settle(2);
    chk_ctl();
    for (i = 'h2C; i < 'h34; i++) rd(7'(i));
    wr(apc_pkg::OFS_INPUT_SIGNAL, 9'h000);
    wr(apc_pkg::OFS_BOOST_CTRL, 9'h070);
    settle(3);
    chk_ctl();
    for (k = 0; k < 64; k++)
    begin
      mic_bias_mode_sel_i = k[0];
      wr(apc_pkg::OFS_INPUT_SIGNAL, 9'(k << 6) | 9'(k >> 3));
      wr(apc_pkg::OFS_PGA_GAIN, 9'(k) | 9'(k << 6 & 'h040));
      wr(apc_pkg::OFS_BOOST_CTRL, 9'(k * 17));
      wr(apc_pkg::OFS_OUTPUT_OPT, 9'(k));
      wr(apc_pkg::OFS_SPK_MIXER, 9'(k * 5));
      settle(3);
      chk_ctl();
    end
    for (k = 0; k < 30; k++)
    begin
      mic_bias_mode_sel_i = 1'($random(seed));
      for (i = 0; i < 2; i++)
      begin
        rv = 9'($random(seed));
        ra = 7'h2C + 7'($random(seed) & 7);
        if (ra == apc_pkg::OFS_PGA_GAIN)
          rv[7] = 1'b0;
        wr(ra, rv);
      end
      settle(2);
      chk_ctl();
      for (i = 'h2C; i < 'h34; i++) rd(7'(i));
    end
    // Sign held still: a deferred gain must wait for the crossing
    wr(apc_pkg::OFS_PGA_GAIN, 9'h010);
    settle(2);
    wr(apc_pkg::OFS_PGA_GAIN, 9'h0A5);
    settle(8);
    chk_ctl();
    pga_signal_sign_i = ~pga_signal_sign_i;
    gcode = 'h25;
    settle(8);
    chk_ctl();
    conclude();
  end
endmodule
